//--- pport_pkg.sv
// Purpose: Shared constants for the two-port mode 0 parallel port block.
// Assumes: APB register map with 32-bit data, one register per aligned word.
// Notes: Handshake pins are asserted high; field positions refer to control bytes.
package pport_pkg;

   // --------
   // Register byte offsets
   // --------
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_GEN_CTRL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_DATA_A = 8'h10;
   localparam logic [7:0] OFF_DATA_B = 8'h14;
   localparam logic [7:0] OFF_DIR_A = 8'h18;
   localparam logic [7:0] OFF_DIR_B = 8'h1c;

   // --------
   // Control byte fields
   // --------
   localparam int CTL_STAT_SEL = 0;
   localparam int CTL_SVC_EN = 1;
   localparam int CTL_AUX_IRQ_EN = 2;
   localparam int CTL_AUX_LSB = 3;
   localparam int CTL_SUB_LSB = 6;
   localparam logic [1:0] SUB_DBUF_OUT = 2'h1;

   // ----------------------------------------------------------------
   // Status register: two bits per port, port B above port A
   // ----------------------------------------------------------------
   localparam int ST_IN_BIT = 0;
   localparam int ST_AUX_BIT = 1;
   localparam int ST_PORT_STRIDE = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [1:0] RST_GEN_CTRL = 2'h0;

   // ----------------------------------------------------------------
   // Handshake timing in clock cycles
   // ----------------------------------------------------------------
   localparam logic [1:0] HS_DELAY_CYC = 2'h2;
   localparam logic [2:0] PULSE_CYC = 3'h4;

endpackage : pport_pkg

//--- pport_mode0.sv
// Purpose: Mode 0 logic of two 8-bit parallel ports with programmable handshakes.
// Assumes: APB slave with one wait state; pins synchronous to i_clock.
// Notes: Handshake negation happens at the next clock edge, not asynchronously.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pport_mode0 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Port A pins
   input wire logic [WIDTH-1:0] i_port_a_pins,
   output logic [WIDTH-1:0] o_port_a_pins,
   output logic [WIDTH-1:0] o_port_a_oe,
   input wire logic i_hs_a_in,
   input wire logic i_hs_a_aux,
   output logic o_hs_a_aux,
   output logic o_hs_a_aux_oe,
   // Port B pins
   input wire logic [WIDTH-1:0] i_port_b_pins,
   output logic [WIDTH-1:0] o_port_b_pins,
   output logic [WIDTH-1:0] o_port_b_oe,
   input wire logic i_hs_b_in,
   input wire logic i_hs_b_aux,
   output logic o_hs_b_aux,
   output logic o_hs_b_aux_oe,
   // Requests
   output logic o_service_request,
   output logic o_dma_request
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] ctrl_reg [2];
   logic [WIDTH-1:0] dir_reg [2];
   logic [WIDTH-1:0] fol_reg [2];
   logic [WIDTH-1:0] iol_reg [2];

   logic fol_full_reg [2];
   logic iol_full_reg [2];

   logic in_q_reg [2];
   logic aux_q_reg [2];
   logic in_flag_reg [2];
   logic aux_flag_reg [2];

   logic aux_on_reg [2];
   logic armed_reg [2];
   logic aux_pin_reg [2];
   logic aux_oe_reg [2];
   logic [1:0] dly_reg [2];
   logic [2:0] pulse_reg [2];

   logic [1:0] gctrl_reg;

   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   logic svc_reg;
   logic dma_reg;

   // ----------------------------------------------------------------
   // Pin bundling
   // ----------------------------------------------------------------
   wire hs_in_w [2];
   wire hs_aux_w [2];
   wire [WIDTH-1:0] pins_w [2];

   wire [1:0] in_stat_w;
   wire [1:0] aux_stat_w;
   wire [1:0] svc_w;
   wire [1:0] dma_w;

   assign hs_in_w[0] = i_hs_a_in;
   assign hs_in_w[1] = i_hs_b_in;
   assign hs_aux_w[0] = i_hs_a_aux;
   assign hs_aux_w[1] = i_hs_b_aux;
   assign pins_w[0] = i_port_a_pins;
   assign pins_w[1] = i_port_b_pins;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // One wait state: pready rises at the first access edge, the transfer
   // completes at the next, which keeps read data coming from a flop.
   wire access_w = i_psel & i_penable;
   wire fire_w = access_w & pready_reg;
   wire wr_fire_w = fire_w & i_pwrite;
   wire hit_w = (i_paddr == pport_pkg::OFF_CTRL_A) | (i_paddr == pport_pkg::OFF_CTRL_B) |
                (i_paddr == pport_pkg::OFF_GEN_CTRL) | (i_paddr == pport_pkg::OFF_STATUS) |
                (i_paddr == pport_pkg::OFF_DATA_A) | (i_paddr == pport_pkg::OFF_DATA_B) |
                (i_paddr == pport_pkg::OFF_DIR_A) | (i_paddr == pport_pkg::OFF_DIR_B);
   wire wr_gctrl_w = wr_fire_w & (i_paddr == pport_pkg::OFF_GEN_CTRL);
   wire wr_status_w = wr_fire_w & (i_paddr == pport_pkg::OFF_STATUS);
   wire [3:0] status_w = {aux_stat_w[1], in_stat_w[1], aux_stat_w[0], in_stat_w[0]};

   // Data reads mix live pins for inputs with the latch for outputs.
   wire [WIDTH-1:0] rd_data_a_w = (pins_w[0] & ~dir_reg[0]) | (fol_reg[0] & dir_reg[0]);
   wire [WIDTH-1:0] rd_data_b_w = (pins_w[1] & ~dir_reg[1]) | (fol_reg[1] & dir_reg[1]);

   wire [31:0] rdata_w =
      (i_paddr == pport_pkg::OFF_CTRL_A) ? {24'h0, ctrl_reg[0]} :
      (i_paddr == pport_pkg::OFF_CTRL_B) ? {24'h0, ctrl_reg[1]} :
      (i_paddr == pport_pkg::OFF_GEN_CTRL) ? {30'h0, gctrl_reg} :
      (i_paddr == pport_pkg::OFF_STATUS) ? {28'h0, status_w} :
      (i_paddr == pport_pkg::OFF_DATA_A) ? 32'(rd_data_a_w) :
      (i_paddr == pport_pkg::OFF_DATA_B) ? 32'(rd_data_b_w) :
      (i_paddr == pport_pkg::OFF_DIR_A) ? 32'(dir_reg[0]) :
      (i_paddr == pport_pkg::OFF_DIR_B) ? 32'(dir_reg[1]) : 32'h0;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access_w & ~pready_reg;
         prdata_reg <= (access_w & ~pready_reg & ~i_pwrite) ? rdata_w : 32'h0;
         pslverr_reg <= access_w & ~pready_reg & ~hit_w;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gctrl_reg <= pport_pkg::RST_GEN_CTRL;
      end else if (wr_gctrl_w) begin
         gctrl_reg <= i_pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Per-port logic
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         localparam logic [7:0] OFF_CTRL = (g == 0) ? pport_pkg::OFF_CTRL_A : pport_pkg::OFF_CTRL_B;
         localparam logic [7:0] OFF_DATA = (g == 0) ? pport_pkg::OFF_DATA_A : pport_pkg::OFF_DATA_B;
         localparam logic [7:0] OFF_DIR = (g == 0) ? pport_pkg::OFF_DIR_A : pport_pkg::OFF_DIR_B;
         localparam int ST_IN = g * pport_pkg::ST_PORT_STRIDE + pport_pkg::ST_IN_BIT;
         localparam int ST_AUX = g * pport_pkg::ST_PORT_STRIDE + pport_pkg::ST_AUX_BIT;

         wire [7:0] ctrl_w = ctrl_reg[g];
         wire [2:0] aux_ctl_w = ctrl_w[pport_pkg::CTL_AUX_LSB +: 3];
         wire sm01_w = ctrl_w[pport_pkg::CTL_SUB_LSB +: 2] == pport_pkg::SUB_DBUF_OUT;
         wire pair_en_w = gctrl_reg[g];
         wire aux_in_w = ~aux_ctl_w[2];

         // Handshake modes exist only with the double-buffered output;
         // in bit I/O the middle field bit is ignored.
         wire hs_mode_w = sm01_w & aux_ctl_w[2] & aux_ctl_w[1];
         wire pulsed_w = hs_mode_w & aux_ctl_w[0];
         wire in_rise_w = hs_in_w[g] & ~in_q_reg[g];
         wire aux_rise_w = hs_aux_w[g] & ~aux_q_reg[g];

         wire wr_ctrl_w = wr_fire_w & (i_paddr == OFF_CTRL);
         wire wr_data_w = wr_fire_w & (i_paddr == OFF_DATA);
         wire wr_dir_w = wr_fire_w & (i_paddr == OFF_DIR);

         wire clr_in_w = wr_status_w & i_pwdata[ST_IN];
         wire clr_aux_w = wr_status_w & i_pwdata[ST_AUX];

         // In a handshake mode, input edges do not touch the data path until the
         // aux pin has been asserted for the byte in the final latch.
         wire ack_w = sm01_w & pair_en_w & in_rise_w & fol_full_reg[g] &
                      (~hs_mode_w | armed_reg[g]);
         wire start_w = hs_mode_w & pair_en_w & (dly_reg[g] == 2'h1);

         logic [WIDTH-1:0] fol_next;
         logic [WIDTH-1:0] iol_next;
         logic fol_full_next;
         logic iol_full_next;
         logic load_next;
         logic aux_on_next;
         logic armed_next;
         logic in_flag_next;
         logic aux_flag_next;

         // Output latches: the initial latch feeds the final latch as soon
         // as the final one is free; a write to two full latches is dropped.
         always_comb begin
            fol_next = fol_reg[g];
            iol_next = iol_reg[g];
            fol_full_next = fol_full_reg[g] & ~ack_w;
            iol_full_next = iol_full_reg[g];
            load_next = 1'b0;
            if (!sm01_w) begin
               fol_full_next = 1'b0;
               iol_full_next = 1'b0;
               if (wr_data_w) begin
                  fol_next = i_pwdata[WIDTH-1:0];
               end
            end else begin
               if (!fol_full_next && iol_full_next) begin
                  fol_next = iol_reg[g];
                  fol_full_next = 1'b1;
                  iol_full_next = 1'b0;
                  load_next = 1'b1;
               end
               if (wr_data_w) begin
                  if (!fol_full_next) begin
                     fol_next = i_pwdata[WIDTH-1:0];
                     fol_full_next = 1'b1;
                     load_next = 1'b1;
                  end else if (!iol_full_next) begin
                     iol_next = i_pwdata[WIDTH-1:0];
                     iol_full_next = 1'b1;
                  end
               end
            end
         end

         // Aux output handshake.
         always_comb begin
            aux_on_next = aux_on_reg[g];
            armed_next = armed_reg[g];
            if (!hs_mode_w || !pair_en_w || ack_w) begin
               aux_on_next = 1'b0;
               armed_next = 1'b0;
            end else if (start_w) begin
               aux_on_next = 1'b1;
               armed_next = 1'b1;
            end else if (pulsed_w && pulse_reg[g] == 3'h1) begin
               aux_on_next = 1'b0;
            end
         end

         // Sticky edge flags; the set beats a software clear in the same cycle.
         always_comb begin
            in_flag_next = in_flag_reg[g];
            aux_flag_next = aux_flag_reg[g];
            if (!pair_en_w || sm01_w) begin
               in_flag_next = 1'b0;
            end else if (in_rise_w) begin
               in_flag_next = 1'b1;
            end else if (clr_in_w) begin
               in_flag_next = 1'b0;
            end
            if (!pair_en_w || !aux_in_w) begin
               aux_flag_next = 1'b0;
            end else if (aux_rise_w) begin
               aux_flag_next = 1'b1;
            end else if (clr_aux_w) begin
               aux_flag_next = 1'b0;
            end
         end

         wire room_w = ~(fol_full_reg[g] & iol_full_reg[g]);
         wire empty_w = ~fol_full_reg[g] & ~iol_full_reg[g];
         wire lvl_w = ctrl_w[pport_pkg::CTL_STAT_SEL] ? empty_w : room_w;
         assign in_stat_w[g] = sm01_w ? lvl_w : in_flag_reg[g];
         assign aux_stat_w[g] = aux_flag_reg[g];
         assign svc_w[g] = (ctrl_w[pport_pkg::CTL_SVC_EN] & in_stat_w[g]) |
                           (ctrl_w[pport_pkg::CTL_AUX_IRQ_EN] & aux_flag_reg[g]);
         assign dma_w[g] = sm01_w & ctrl_w[pport_pkg::CTL_SVC_EN] & in_stat_w[g];

         // Fixed levels come from the low field bit in both submodes.
         wire aux_pin_next = hs_mode_w ? aux_on_next : (aux_ctl_w[2] & aux_ctl_w[0]);

         always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               ctrl_reg[g] <= pport_pkg::RST_CTRL;
               dir_reg[g] <= WIDTH'(pport_pkg::RST_DIR);
               fol_reg[g] <= WIDTH'(pport_pkg::RST_DATA);
               iol_reg[g] <= WIDTH'(pport_pkg::RST_DATA);
               fol_full_reg[g] <= 1'b0;
               iol_full_reg[g] <= 1'b0;
               in_q_reg[g] <= 1'b0;
               aux_q_reg[g] <= 1'b0;
               in_flag_reg[g] <= 1'b0;
               aux_flag_reg[g] <= 1'b0;
               aux_on_reg[g] <= 1'b0;
               armed_reg[g] <= 1'b0;
               aux_pin_reg[g] <= 1'b0;
               aux_oe_reg[g] <= 1'b0;
               dly_reg[g] <= 2'h0;
               pulse_reg[g] <= 3'h0;
            end else begin
               if (wr_ctrl_w) begin
                  ctrl_reg[g] <= i_pwdata[7:0];
               end
               if (wr_dir_w) begin
                  dir_reg[g] <= i_pwdata[WIDTH-1:0];
               end
               fol_reg[g] <= fol_next;
               iol_reg[g] <= iol_next;
               fol_full_reg[g] <= fol_full_next;
               iol_full_reg[g] <= iol_full_next;
               in_q_reg[g] <= hs_in_w[g];
               aux_q_reg[g] <= hs_aux_w[g];
               in_flag_reg[g] <= in_flag_next;
               aux_flag_reg[g] <= aux_flag_next;
               aux_on_reg[g] <= aux_on_next;
               armed_reg[g] <= armed_next;
               aux_pin_reg[g] <= aux_pin_next;
               aux_oe_reg[g] <= aux_ctl_w[2];
               dly_reg[g] <= load_next ? pport_pkg::HS_DELAY_CYC :
                             (dly_reg[g] != 2'h0) ? dly_reg[g] - 2'h1 : 2'h0;
               pulse_reg[g] <= start_w ? pport_pkg::PULSE_CYC :
                               (pulse_reg[g] != 3'h0) ? pulse_reg[g] - 3'h1 : 3'h0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Requests
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         svc_reg <= 1'b0;
         dma_reg <= 1'b0;
      end else begin
         svc_reg <= |svc_w;
         dma_reg <= |dma_w;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_pready = pready_reg;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg;

   assign o_port_a_pins = fol_reg[0];
   assign o_port_a_oe = dir_reg[0];
   assign o_port_b_pins = fol_reg[1];
   assign o_port_b_oe = dir_reg[1];

   assign o_hs_a_aux = aux_pin_reg[0];
   assign o_hs_a_aux_oe = aux_oe_reg[0];
   assign o_hs_b_aux = aux_pin_reg[1];
   assign o_hs_b_aux_oe = aux_oe_reg[1];

   assign o_service_request = svc_reg;
   assign o_dma_request = dma_reg;

endmodule : pport_mode0

//--- pport_peer.sv
// Purpose: Peripheral taking bytes offered on a handshake.
// Assumes: Strobe and acknowledge active high.
// Notes: One-cycle acknowledge after a bench-set wait.
`timescale 1ns/1ps
module pport_peer (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // From the port and the bench
   input wire logic i_strobe,
   input wire logic [7:0] i_data,
   input wire logic [3:0] i_delay,
   // To the port and the bench
   output logic o_ack,
   output logic [7:0] o_last,
   output logic [7:0] o_count
);
   logic [1:0] state_reg;
   logic [3:0] wait_reg;

   // A long wait lets the pulsed strobe run out before the acknowledge.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= 2'h0;
         wait_reg <= 4'h0;
         o_ack <= 1'b0;
         o_last <= 8'h00;
         o_count <= 8'h00;
      end else begin
         case (state_reg)
            2'h0: if (i_strobe) begin
               o_last <= i_data;
               o_count <= o_count + 8'h01;
               wait_reg <= i_delay;
               state_reg <= 2'h1;
            end
            2'h1: if (wait_reg == 4'h0) begin
               o_ack <= 1'b1;
               state_reg <= 2'h2;
            end else begin
               wait_reg <= wait_reg - 4'h1;
            end
            2'h2: begin
               o_ack <= 1'b0;
               state_reg <= 2'h3;
            end
            default: if (!i_strobe) begin
               state_reg <= 2'h0;
            end
         endcase
      end
   end
endmodule : pport_peer

//--- pport_mode0_chk.sv
// Purpose: Port-level assertions for the port block.
// Assumes: One clock, async active-low reset.
// Notes: Register shadows tie pin outputs to settings.
`timescale 1ns/1ps
module pport_mode0_chk #(
   parameter int WIDTH = 8
) (
   // Clock, reset and bus
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   // Pins and requests
   input wire logic [WIDTH-1:0] o_port_a_oe,
   input wire logic i_hs_a_in,
   input wire logic o_hs_a_aux,
   input wire logic o_hs_a_aux_oe,
   input wire logic o_hs_b_aux,
   input wire logic o_service_request,
   input wire logic o_dma_request
);
   logic [7:0] ctl_a;
   logic [7:0] ctl_b;
   logic [WIDTH-1:0] dir_a;
   logic [1:0] age;
   wire wr_done = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
   wire settled = age == 2'h3;
   wire fix_a = ctl_a[5] && (ctl_a[7:6] != 2'h1 || !ctl_a[4]);
   wire dma_ok = (ctl_a[7:6] == 2'h1 && ctl_a[1]) || (ctl_b[7:6] == 2'h1 && ctl_b[1]);

   // Outputs are given three edges to follow a register write.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_a <= 8'h00;
         ctl_b <= 8'h00;
         dir_a <= '0;
         age <= 2'h3;
      end else begin
         age <= wr_done ? 2'h0 : age + {1'b0, age != 2'h3};
         ctl_a <= (wr_done && i_paddr == pport_pkg::OFF_CTRL_A) ? i_pwdata[7:0] : ctl_a;
         ctl_b <= (wr_done && i_paddr == pport_pkg::OFF_CTRL_B) ? i_pwdata[7:0] : ctl_b;
         dir_a <= (wr_done && i_paddr == pport_pkg::OFF_DIR_A) ? i_pwdata[WIDTH-1:0] : dir_a;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("ready late");
   a_ready_once: assert property (o_pready |=> !o_pready) else $error("ready too long");
   a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("data idle");
   a_err_map: assert property (o_pready && i_paddr[1:0] == 2'h0
      |-> o_pslverr == (i_paddr > pport_pkg::OFF_DIR_B)) else $error("slave error");
   a_dir_drive: assert property (settled |-> o_port_a_oe == dir_a)
      else $error("driver enable");
   a_aux_dir: assert property (settled |-> o_hs_a_aux_oe == ctl_a[5])
      else $error("aux enable");
   a_aux_fixed: assert property (settled && fix_a |-> o_hs_a_aux == ctl_a[3])
      else $error("aux level");
   a_dma_gate: assert property (settled && !dma_ok |-> !o_dma_request)
      else $error("dma request");
   a_pulse_max: assert property (ctl_b[7:3] == 5'h0f && $rose(o_hs_b_aux)
      |-> ##[1:4] !o_hs_b_aux) else $error("pulse long");
   a_ack_drop: assert property (ctl_a[7:3] == 5'h0e && o_hs_a_aux && i_hs_a_in
      && !$past(i_hs_a_in) |=> !o_hs_a_aux) else $error("aux held");

   c_pulse: cover property ($rose(o_hs_b_aux));
   c_dma: cover property ($rose(o_dma_request));
   c_svc: cover property ($rose(o_service_request));
   c_err: cover property (o_pslverr);
endmodule : pport_mode0_chk

bind pport_mode0 pport_mode0_chk #(.WIDTH(WIDTH)) u_chk (.i_clock, .i_rst_n, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
   .o_port_a_oe, .i_hs_a_in, .o_hs_a_aux, .o_hs_a_aux_oe, .o_hs_b_aux,
   .o_service_request, .o_dma_request);

//--- tb.sv
// Purpose: Self-checking bench for the port block.
// Assumes: Peers acknowledge the aux strobes.
// Notes: Undriven data pins read fixed patterns.
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] PAT_A = 8'h3c;
   localparam logic [7:0] PAT_B = 8'h96;
   localparam logic [7:0] FIX_V [6] = '{8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'h60, 8'h68};
   localparam logic [16:0] SVC_T [5] = '{{8'h84, 8'h80, 1'b1}, {8'h80, 8'h84, 1'b1},
      {8'h82, 8'h80, 1'b1}, {8'h80, 8'h82, 1'b1}, {8'h80, 8'h80, 1'b0}};
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata, rd;
   logic o_pready, o_pslverr, o_hs_a_aux, o_hs_a_aux_oe, o_hs_b_aux, o_hs_b_aux_oe;
   logic o_service_request, o_dma_request, ack_a, ack_b, err;
   logic [7:0] o_port_a_pins, o_port_a_oe, o_port_b_pins, o_port_b_oe;
   logic [7:0] last_a, last_b, cnt_a, cnt_b;
   logic [3:0] hs_poke = 4'h0;
   logic [3:0] dly_a = 4'h9;
   logic [3:0] dly_b = 4'h0;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   wire logic [7:0] i_port_a_pins = (o_port_a_oe & o_port_a_pins) | (~o_port_a_oe & PAT_A);
   wire logic [7:0] i_port_b_pins = (o_port_b_oe & o_port_b_pins) | (~o_port_b_oe & PAT_B);
   wire logic i_hs_a_in = ack_a | hs_poke[3];
   wire logic i_hs_a_aux = o_hs_a_aux_oe ? o_hs_a_aux : hs_poke[2];
   wire logic i_hs_b_in = ack_b | hs_poke[1];
   wire logic i_hs_b_aux = o_hs_b_aux_oe ? o_hs_b_aux : hs_poke[0];

   always #4 i_clock = ~i_clock;

   pport_mode0 DUT (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_port_a_pins, .o_port_a_pins,
      .o_port_a_oe, .i_hs_a_in, .i_hs_a_aux, .o_hs_a_aux, .o_hs_a_aux_oe, .i_port_b_pins,
      .o_port_b_pins, .o_port_b_oe, .i_hs_b_in, .i_hs_b_aux, .o_hs_b_aux, .o_hs_b_aux_oe,
      .o_service_request, .o_dma_request);
   pport_peer u_peer_a (.i_clock, .i_rst_n, .i_strobe(o_hs_a_aux), .i_data(o_port_a_pins),
      .i_delay(dly_a), .o_ack(ack_a), .o_last(last_a), .o_count(cnt_a));
   pport_peer u_peer_b (.i_clock, .i_rst_n, .i_strobe(o_hs_b_aux), .i_data(o_port_b_pins),
      .i_delay(dly_b), .o_ack(ack_b), .o_last(last_b), .o_count(cnt_b));

   // --------
   // Bus and check tasks
   // --------
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Waits one edge first so a request never follows a release in one step.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= addr;
      i_pwdata <= wd;
      @(posedge i_clock);
      i_penable <= 1'b1;
      @(posedge i_clock);
      while (o_pready !== 1'b1) begin
         @(posedge i_clock);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      apb(1'b1, addr, wd);
   endtask : wr

   task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      check(rd, exp);
   endtask : rdc

   task automatic rds();
      apb(1'b0, pport_pkg::OFF_STATUS, 32'h0);
   endtask : rds

   task automatic poke(input logic [3:0] pins);
      @(posedge i_clock);
      hs_poke <= pins;
      @(posedge i_clock);
      hs_poke <= 4'h0;
   endtask : poke

   task automatic wait_count(input logic [7:0] want, input logic port_b);
      while ((port_b ? cnt_b : cnt_a) !== want) begin
         @(posedge i_clock);
      end
   endtask : wait_count

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   // --------
   // Tests
   // --------
   initial begin
      logic [7:0] base;
      int n;
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rdc(pport_pkg::OFF_STATUS, 32'h0);
      wr(pport_pkg::OFF_CTRL_A, 32'hffff_ffa5);
      rdc(pport_pkg::OFF_CTRL_A, 32'ha5);
      apb(1'b0, 8'h20, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         wr(pport_pkg::OFF_CTRL_A + 8'(4 * p), 32'h80);
         wr(pport_pkg::OFF_DIR_A + 8'(4 * p), 32'hf0);
         wr(pport_pkg::OFF_DATA_A + 8'(4 * p), 32'h5a);
         rdc(pport_pkg::OFF_DATA_A + 8'(4 * p), 8'h50 | (8'h0f & (p ? PAT_B : PAT_A)));
         check(p ? {o_port_b_oe, o_port_b_pins} : {o_port_a_oe, o_port_a_pins}, 16'hf05a);
      end
      $display("test bit io done");
      wr(pport_pkg::OFF_GEN_CTRL, 32'h3);
      poke(4'hc);
      rdc(pport_pkg::OFF_STATUS, 32'h3);
      check(o_service_request, 1'b0);
      poke(4'h3);
      for (int k = 0; k < 5; k++) begin
         wr(pport_pkg::OFF_CTRL_A, SVC_T[k][16:9]);
         wr(pport_pkg::OFF_CTRL_B, SVC_T[k][8:1]);
         rdc(pport_pkg::OFF_STATUS, 32'hf);
         check({o_service_request, o_dma_request}, {SVC_T[k][0], 1'b0});
      end
      wr(pport_pkg::OFF_STATUS, 32'h2);
      rdc(pport_pkg::OFF_STATUS, 32'hd);
      wr(pport_pkg::OFF_GEN_CTRL, 32'h2);
      rdc(pport_pkg::OFF_STATUS, 32'hc);
      wr(pport_pkg::OFF_STATUS, 32'hf);
      rdc(pport_pkg::OFF_STATUS, 32'h0);
      $display("test flags done");
      for (int k = 0; k < 6; k++) begin
         wr(pport_pkg::OFF_CTRL_A, FIX_V[k]);
         wr(pport_pkg::OFF_CTRL_B, FIX_V[k]);
         rdc(pport_pkg::OFF_CTRL_A, FIX_V[k]);
         check({o_hs_a_aux_oe, o_hs_b_aux_oe, o_hs_a_aux, o_hs_b_aux}, {2'h3, {2{FIX_V[k][3]}}});
      end
      $display("test fixed levels done");
      wr(pport_pkg::OFF_GEN_CTRL, 32'h1);
      wr(pport_pkg::OFF_CTRL_A, 32'h72);
      rds();
      check({rd[0], o_dma_request}, 2'h3);
      base = cnt_a;
      wr(pport_pkg::OFF_DATA_A, 32'h11);
      @(posedge i_clock);
      #1 check(o_hs_a_aux, 1'b0);
      @(posedge i_clock);
      #1 check(o_hs_a_aux, 1'b1);
      wr(pport_pkg::OFF_DATA_A, 32'h22);
      rds();
      check({rd[0], o_dma_request}, 2'h0);
      for (int k = 1; k < 4; k++) begin
         if (k == 3) begin
            wr(pport_pkg::OFF_DATA_A, 32'h33);
         end
         wait_count(base + 8'(k), 1'b0);
         check(last_a, 8'(k * 17));
      end
      wait (o_hs_a_aux === 1'b0);
      wr(pport_pkg::OFF_CTRL_A, 32'h73);
      rds();
      check({rd[0], o_dma_request}, 2'h3);
      wr(pport_pkg::OFF_DATA_A, 32'h44);
      rds();
      check(rd[0], 1'b0);
      wr(pport_pkg::OFF_CTRL_A, 32'h71);
      rdc(pport_pkg::OFF_CTRL_A, 32'h71);
      check({o_service_request, o_dma_request}, 2'h0);
      $display("test interlocked done");
      wr(pport_pkg::OFF_GEN_CTRL, 32'h2);
      wr(pport_pkg::OFF_CTRL_B, 32'h7b);
      rds();
      check(rd[2], 1'b1);
      wr(pport_pkg::OFF_CTRL_B, 32'h7a);
      rds();
      check(o_dma_request, 1'b1);
      for (int k = 0; k < 2; k++) begin
         dly_b <= k ? 4'h9 : 4'h0;
         base = cnt_b;
         wr(pport_pkg::OFF_DATA_B, 32'h44 + k);
         while (o_hs_b_aux !== 1'b1) begin
            @(posedge i_clock);
         end
         n = 0;
         while (o_hs_b_aux === 1'b1) begin
            @(posedge i_clock);
            n++;
         end
         check(n, k ? 4 : 3);
         wait_count(base + 8'h1, 1'b1);
         check(last_b, 8'h44 + 8'(k));
      end
      $display("test pulsed done");
      stop_test();
   end
endmodule : tb
